// ### core/gpm_pad_bank.sv
// Registered pad control for one port: output value, enable and pull-high.
// Assumes per-pin routing flags are already decoded by the caller.
`timescale 1ns/1ns
module gpm_pad_bank
  import gpm_pkg::*;
#(
  parameter int unsigned W = 8
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Per-pin controls
  input wire logic [W-1:0] dir_in_mode,
  input wire logic [W-1:0] latch,
  input wire logic [W-1:0] pull_en,
  input wire logic [W-1:0] alt_drive,
  input wire logic [W-1:0] alt_value,
  input wire logic [W-1:0] analog,
  input wire logic [W-1:0] no_drive,
  // Pad side
  output logic [W-1:0] pad_out,
  output logic [W-1:0] pad_oe,
  output logic [W-1:0] pad_pull
);

  logic [W-1:0] out_d;
  logic [W-1:0] oe_d;
  logic [W-1:0] pull_d;

  // A compare output overrides the direction bit; analog kills the driver
  // Per-bit select: a vector condition would let one compare pin steer the whole port
  assign out_d = (alt_drive & alt_value) | (~alt_drive & latch);
  assign oe_d = ~analog & ~no_drive & (alt_drive | ~dir_in_mode);
  // Pull-high only on a digital input; push-pull drivers never pull
  assign pull_d = pull_en & ~analog & ~alt_drive & dir_in_mode;

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pad_out <= '1;
      pad_oe <= '0;
      pad_pull <= '0;
    end
    else
    begin
      pad_out <= out_d;
      pad_oe <= oe_d;
      pad_pull <= pull_d;
    end
  end

endmodule : gpm_pad_bank

// ### core/gpm_pkg.sv
// Constants for the two-port GPIO block with pin-shared function routing.
// Assumes an 8-bit data-memory style register port inside the device.
package gpm_pkg;

  localparam int unsigned PORT_A_W = 8;
  localparam int unsigned PORT_B_W = 7;

  // Register addresses on the data-memory port
  localparam logic [7:0] ADDR_PORT_A_DATA = 8'h00;
  localparam logic [7:0] ADDR_PORT_A_DIR = 8'h01;
  localparam logic [7:0] ADDR_PORT_A_PU = 8'h02;
  localparam logic [7:0] ADDR_PORT_A_WAKE = 8'h03;
  localparam logic [7:0] ADDR_PORT_B_DATA = 8'h04;
  localparam logic [7:0] ADDR_PORT_B_DIR = 8'h05;
  localparam logic [7:0] ADDR_PORT_B_PU = 8'h06;
  localparam logic [7:0] ADDR_FSEL_A_LOW = 8'h07;
  localparam logic [7:0] ADDR_FSEL_A_HIGH = 8'h08;
  localparam logic [7:0] ADDR_FSEL_B = 8'h09;
  localparam logic [7:0] ADDR_RESET_SEL = 8'h0a;

  // Reset values
  localparam logic [7:0] RST_PORT_A_DATA = 8'hff;
  localparam logic [7:0] RST_PORT_A_DIR = 8'hff;
  localparam logic [7:0] RST_PORT_A_PU = 8'h00;
  localparam logic [7:0] RST_PORT_A_WAKE = 8'h00;
  localparam logic [7:0] RST_PORT_B_DATA = 8'h5f;
  localparam logic [7:0] RST_PORT_B_DIR = 8'h7f;
  localparam logic [7:0] RST_PORT_B_PU = 8'h00;
  localparam logic [7:0] RST_FSEL = 8'h00;
  localparam logic [7:0] RST_RESET_SEL = 8'h55;

  // Implemented bit masks
  localparam logic [7:0] MASK_PORT_B_DATA = 8'h5f;
  localparam logic [7:0] MASK_PORT_B_CTL = 8'h7f;
  localparam logic [7:0] MASK_FSEL_A_LOW = 8'hcc;
  localparam logic [7:0] MASK_FSEL_A_HIGH = 8'hfc;
  localparam logic [7:0] MASK_FSEL_B = 8'hff;

  // Selector field positions (low bit of each 2-bit field)
  localparam int unsigned FLD_A3 = 6;
  localparam int unsigned FLD_A1 = 2;
  localparam int unsigned FLD_A7 = 6;
  localparam int unsigned FLD_A6 = 4;
  localparam int unsigned FLD_A5 = 2;
  localparam int unsigned FLD_B3 = 6;
  localparam int unsigned FLD_B2 = 4;
  localparam int unsigned FLD_B1 = 2;
  localparam int unsigned FLD_B0 = 0;

  // Selector codes
  localparam logic [1:0] FN_ALT1 = 2'h1;
  localparam logic [1:0] FN_ALT2 = 2'h2;

  // Reset pin select codes
  localparam logic [7:0] RSEL_GPIO = 8'h55;
  localparam logic [7:0] RSEL_RESET = 8'haa;

  // Pin bit positions
  localparam int unsigned PIN_A1 = 1;
  localparam int unsigned PIN_A3 = 3;
  localparam int unsigned PIN_A5 = 5;
  localparam int unsigned PIN_A6 = 6;
  localparam int unsigned PIN_A7 = 7;
  localparam int unsigned PIN_B0 = 0;
  localparam int unsigned PIN_B1 = 1;
  localparam int unsigned PIN_B2 = 2;
  localparam int unsigned PIN_B3 = 3;
  localparam int unsigned PIN_B4 = 4;

  typedef enum logic [1:0] {
    GPM_FN_GPIO = 2'h0,
    GPM_FN_DRIVE = 2'h1,
    GPM_FN_ANALOG = 2'h3
  } gpm_fn_t;

endpackage : gpm_pkg

// ### core/gpm_port_top.sv
// How it works
// - Reads of input pins sample the live pin level on the clock edge of the read; port B pin 5 reads zero.
// - Written port data stays in an output latch until rewritten.
// - Pull-high bit 1 enables the pull, only on logic-input pins.
// - With wake enabled, a falling edge on a port A pin wakes the device.
// - Wake only acts on general purpose pins during idle or sleep.
// - Wake enable bits 7..0 map to port A pins 7..0, 1 enables.
// - Direction bit 1 makes an input, 0 a push-pull output.
// - Reading an output pin returns the latch, not the pin level.
// - Port A pin 3 code 01 is analog channel 4, else GPIO with timer0 clock.
// - Port A pin 1: 01 timer0 compare, 10 reference input, else GPIO.
// - Port A pin 7 code 01 is analog channel 7, else GPIO.
// - Port A pin 6 code 01 is analog channel 6, else GPIO.
// - Port A pin 5 code 01 is analog channel 5, else GPIO with timer0 capture.
// - Port B pin 3 code 01 is analog channel 3, else GPIO.
// - Port B pin 2 code 01 is analog channel 2, else GPIO with timer1 capture.
// - Port B pin 1 code 01 is analog channel 1, else GPIO with timer1 clock.
// - Port B pin 0: 01 timer1 compare, 10 analog channel 0, else GPIO.
// - Unimplemented selector bits ignore writes and read zero.
// - Port B pin 4 is GPIO for 0x55 and active-low reset input for 0xaa.
//
// Top of the GPIO ports with pin-shared function routing.
// Assumes the core issues one-cycle read and write strobes with a stable address.
`timescale 1ns/1ns
module gpm_port_top
  import gpm_pkg::*;
#(
  parameter int unsigned A_W = PORT_A_W,
  parameter int unsigned B_W = PORT_B_W
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Data-memory register port
  input wire logic [7:0] mem_addr,
  input wire logic mem_wr,
  input wire logic mem_rd,
  input wire logic [7:0] mem_wdata,
  output logic [7:0] mem_rdata_q,
  // Power mode
  input wire logic low_power_mode,
  output logic wake_q,
  // Port A pins
  input wire logic [A_W-1:0] port_a_in,
  output logic [A_W-1:0] port_a_out,
  output logic [A_W-1:0] port_a_oe,
  output logic [A_W-1:0] port_a_pull,
  // Port B pins
  input wire logic [B_W-1:0] port_b_in,
  output logic [B_W-1:0] port_b_out,
  output logic [B_W-1:0] port_b_oe,
  output logic [B_W-1:0] port_b_pull,
  // Timer compare outputs toward the pins
  input wire logic timer0_compare_output,
  input wire logic timer1_compare_output,
  // Routed inputs toward peripherals
  output logic timer0_clock_input_q,
  output logic timer0_capture_input_q,
  output logic timer1_clock_input_q,
  output logic timer1_capture_input_q,
  output logic external_reset_n_q,
  // Analog routing
  output logic [7:0] analog_channel_en_q,
  output logic vref_en_q
);

  function automatic logic [1:0] field(input logic [7:0] r, input int unsigned lsb);
    field = r[lsb +: 2];
  endfunction : field

  function automatic logic [7:0] merge(input logic [7:0] old, input logic [7:0] wd, input logic [7:0] m);
    merge = (wd & m) | (old & ~m);
  endfunction : merge

  // Registers
  logic [7:0] port_a_data_latch_q;
  logic [7:0] port_a_direction_q;
  logic [7:0] port_a_pullup_enable_q;
  logic [7:0] port_a_wake_enable_q;
  logic [7:0] port_b_data_latch_q;
  logic [7:0] port_b_direction_q;
  logic [7:0] port_b_pullup_enable_q;
  logic [7:0] port_a_function_select_low_q;
  logic [7:0] port_a_function_select_high_q;
  logic [7:0] port_b_function_select_q;
  logic [7:0] external_reset_select_q;
  logic [A_W-1:0] port_a_prev_q;

  // Address decode
  wire wr_a_data = mem_wr && (mem_addr == ADDR_PORT_A_DATA);
  wire wr_a_dir = mem_wr && (mem_addr == ADDR_PORT_A_DIR);
  wire wr_a_pu = mem_wr && (mem_addr == ADDR_PORT_A_PU);
  wire wr_a_wake = mem_wr && (mem_addr == ADDR_PORT_A_WAKE);
  wire wr_b_data = mem_wr && (mem_addr == ADDR_PORT_B_DATA);
  wire wr_b_dir = mem_wr && (mem_addr == ADDR_PORT_B_DIR);
  wire wr_b_pu = mem_wr && (mem_addr == ADDR_PORT_B_PU);
  wire wr_fs_al = mem_wr && (mem_addr == ADDR_FSEL_A_LOW);
  wire wr_fs_ah = mem_wr && (mem_addr == ADDR_FSEL_A_HIGH);
  wire wr_fs_b = mem_wr && (mem_addr == ADDR_FSEL_B);
  wire wr_rsel = mem_wr && (mem_addr == ADDR_RESET_SEL);

  // Pin routing decode
  wire [1:0] sel_a3 = field(port_a_function_select_low_q, FLD_A3);
  wire [1:0] sel_a1 = field(port_a_function_select_low_q, FLD_A1);
  wire [1:0] sel_a7 = field(port_a_function_select_high_q, FLD_A7);
  wire [1:0] sel_a6 = field(port_a_function_select_high_q, FLD_A6);
  wire [1:0] sel_a5 = field(port_a_function_select_high_q, FLD_A5);
  wire [1:0] sel_b3 = field(port_b_function_select_q, FLD_B3);
  wire [1:0] sel_b2 = field(port_b_function_select_q, FLD_B2);
  wire [1:0] sel_b1 = field(port_b_function_select_q, FLD_B1);
  wire [1:0] sel_b0 = field(port_b_function_select_q, FLD_B0);

  wire an4_sel = (sel_a3 == FN_ALT1);
  wire tm0_cmp_sel = (sel_a1 == FN_ALT1);
  wire vref_sel = (sel_a1 == FN_ALT2);
  wire an7_sel = (sel_a7 == FN_ALT1);
  wire an6_sel = (sel_a6 == FN_ALT1);
  wire an5_sel = (sel_a5 == FN_ALT1);
  wire an3_sel = (sel_b3 == FN_ALT1);
  wire an2_sel = (sel_b2 == FN_ALT1);
  wire an1_sel = (sel_b1 == FN_ALT1);
  wire tm1_cmp_sel = (sel_b0 == FN_ALT1);
  wire an0_sel = (sel_b0 == FN_ALT2);
  wire b4_reset_sel = (external_reset_select_q == RSEL_RESET);

  wire [7:0] a_analog = {an7_sel, an6_sel, an5_sel, 1'b0, an4_sel, 1'b0, vref_sel, 1'b0};
  wire [7:0] a_drive = {6'h00, tm0_cmp_sel, 1'b0};
  wire [7:0] b_analog = {4'h0, an3_sel, an2_sel, an1_sel, an0_sel};
  wire [7:0] b_drive = {7'h00, tm1_cmp_sel};
  wire [7:0] b_nodrive = {3'h0, b4_reset_sel, 4'h0};
  wire [7:0] a_gpio = ~(a_analog | a_drive);

  wire [A_W-1:0] a_alt_value = {A_W{timer0_compare_output}};
  wire [B_W-1:0] b_alt_value = {B_W{timer1_compare_output}};

  // Read view: input pins show the live level, outputs the latch; port B pin 5 reads zero
  wire [7:0] a_view = (port_a_direction_q & port_a_in) | (~port_a_direction_q & port_a_data_latch_q);
  wire [7:0] b_pins = {1'b0, port_b_in};
  wire [7:0] b_view = ((port_b_direction_q & b_pins) | (~port_b_direction_q & port_b_data_latch_q))
                      & MASK_PORT_B_DATA;

  logic [7:0] rd_mux;
  always_comb
  begin
    case (mem_addr)
      ADDR_PORT_A_DATA: rd_mux = a_view;
      ADDR_PORT_A_DIR: rd_mux = port_a_direction_q;
      ADDR_PORT_A_PU: rd_mux = port_a_pullup_enable_q;
      ADDR_PORT_A_WAKE: rd_mux = port_a_wake_enable_q;
      ADDR_PORT_B_DATA: rd_mux = b_view;
      ADDR_PORT_B_DIR: rd_mux = port_b_direction_q;
      ADDR_PORT_B_PU: rd_mux = port_b_pullup_enable_q;
      ADDR_FSEL_A_LOW: rd_mux = port_a_function_select_low_q;
      ADDR_FSEL_A_HIGH: rd_mux = port_a_function_select_high_q;
      ADDR_FSEL_B: rd_mux = port_b_function_select_q;
      ADDR_RESET_SEL: rd_mux = external_reset_select_q;
      default: rd_mux = 8'h00;
    endcase
  end

  // Falling edge on a general purpose pin while asleep; pins are synchronous
  wire [7:0] a_fall = port_a_prev_q & ~port_a_in;
  wire wake_d = low_power_mode && |(a_fall & port_a_wake_enable_q & a_gpio);

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      port_a_data_latch_q <= RST_PORT_A_DATA;
      port_a_direction_q <= RST_PORT_A_DIR;
      port_a_pullup_enable_q <= RST_PORT_A_PU;
      port_a_wake_enable_q <= RST_PORT_A_WAKE;
      port_b_data_latch_q <= RST_PORT_B_DATA;
      port_b_direction_q <= RST_PORT_B_DIR;
      port_b_pullup_enable_q <= RST_PORT_B_PU;
    end
    else
    begin
      if (wr_a_data) port_a_data_latch_q <= mem_wdata;
      if (wr_a_dir) port_a_direction_q <= mem_wdata;
      if (wr_a_pu) port_a_pullup_enable_q <= mem_wdata;
      if (wr_a_wake) port_a_wake_enable_q <= mem_wdata;
      if (wr_b_data) port_b_data_latch_q <= mem_wdata & MASK_PORT_B_DATA;
      if (wr_b_dir) port_b_direction_q <= mem_wdata & MASK_PORT_B_CTL;
      if (wr_b_pu) port_b_pullup_enable_q <= mem_wdata & MASK_PORT_B_CTL;
    end
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      port_a_function_select_low_q <= RST_FSEL;
      port_a_function_select_high_q <= RST_FSEL;
      port_b_function_select_q <= RST_FSEL;
      external_reset_select_q <= RST_RESET_SEL;
    end
    else
    begin
      // Unimplemented selector bits stay zero
      if (wr_fs_al) port_a_function_select_low_q <= merge(8'h00, mem_wdata, MASK_FSEL_A_LOW);
      if (wr_fs_ah) port_a_function_select_high_q <= merge(8'h00, mem_wdata, MASK_FSEL_A_HIGH);
      if (wr_fs_b) port_b_function_select_q <= merge(8'h00, mem_wdata, MASK_FSEL_B);
      if (wr_rsel) external_reset_select_q <= mem_wdata;
    end
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mem_rdata_q <= 8'h00;
      port_a_prev_q <= '0;
      wake_q <= 1'b0;
    end
    else
    begin
      if (mem_rd) mem_rdata_q <= rd_mux;
      // Edge history runs always so a stale level cannot fake an edge on entry
      port_a_prev_q <= port_a_in;
      wake_q <= wake_d;
    end
  end

  // Routed peripheral inputs: gated low when the pin is analog
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      timer0_clock_input_q <= 1'b0;
      timer0_capture_input_q <= 1'b0;
      timer1_clock_input_q <= 1'b0;
      timer1_capture_input_q <= 1'b0;
      external_reset_n_q <= 1'b1;
      analog_channel_en_q <= 8'h00;
      vref_en_q <= 1'b0;
    end
    else
    begin
      timer0_clock_input_q <= port_a_in[PIN_A3] & ~an4_sel;
      timer0_capture_input_q <= port_a_in[PIN_A5] & ~an5_sel;
      timer1_clock_input_q <= port_b_in[PIN_B1] & ~an1_sel;
      timer1_capture_input_q <= port_b_in[PIN_B2] & ~an2_sel;
      external_reset_n_q <= b4_reset_sel ? port_b_in[PIN_B4] : 1'b1;
      analog_channel_en_q <= {an7_sel, an6_sel, an5_sel, an4_sel, an3_sel, an2_sel, an1_sel, an0_sel};
      vref_en_q <= vref_sel;
    end
  end

  gpm_pad_bank #(.W(A_W)) u_pad_a (
    .clock(clock),
    .rst_n(rst_n),
    .dir_in_mode(port_a_direction_q[A_W-1:0]),
    .latch(port_a_data_latch_q[A_W-1:0]),
    .pull_en(port_a_pullup_enable_q[A_W-1:0]),
    .alt_drive(a_drive[A_W-1:0]),
    .alt_value(a_alt_value),
    .analog(a_analog[A_W-1:0]),
    .no_drive({A_W{1'b0}}),
    .pad_out(port_a_out),
    .pad_oe(port_a_oe),
    .pad_pull(port_a_pull)
  );

  gpm_pad_bank #(.W(B_W)) u_pad_b (
    .clock(clock),
    .rst_n(rst_n),
    .dir_in_mode(port_b_direction_q[B_W-1:0]),
    .latch(port_b_data_latch_q[B_W-1:0]),
    .pull_en(port_b_pullup_enable_q[B_W-1:0]),
    .alt_drive(b_drive[B_W-1:0]),
    .alt_value(b_alt_value),
    .analog(b_analog[B_W-1:0]),
    .no_drive(b_nodrive[B_W-1:0]),
    .pad_out(port_b_out),
    .pad_oe(port_b_oe),
    .pad_pull(port_b_pull)
  );

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);

  // Every output is registered, so checks look one edge past the cause

  live_read_a: assert property ((mem_rd && mem_addr == ADDR_PORT_A_DATA && port_a_direction_q == 8'hff)
    |=> mem_rdata_q == $past(port_a_in))
    else $error("input read did not return live pin level");

  latch_read_a: assert property ((mem_rd && mem_addr == ADDR_PORT_A_DATA && port_a_direction_q == 8'h00)
    |=> mem_rdata_q == $past(port_a_data_latch_q))
    else $error("output read did not return latch");

  latch_hold_a: assert property (!wr_a_data |=> $stable(port_a_data_latch_q))
    else $error("port A latch changed without write");

  drive_out_a: assert property ((port_a_direction_q[0] == 1'b0 && !wr_a_dir)
    |=> port_a_oe[0] && port_a_out[0] == $past(port_a_data_latch_q[0]))
    else $error("output pin not driven from latch");

  pull_gate_a: assert property ((port_a_direction_q[2] == 1'b0) |=> !port_a_pull[2])
    else $error("pull-high on an output pin");

  wake_fall_a: assert property ((low_power_mode && port_a_wake_enable_q[0] && port_a_prev_q[0] && !port_a_in[0])
    |=> wake_q)
    else $error("falling edge did not wake");

  wake_awake_a: assert property (!low_power_mode |=> !wake_q)
    else $error("wake outside low-power mode");

  analog_off_a: assert property (an7_sel |=> !port_a_oe[PIN_A7] && !port_a_pull[PIN_A7])
    else $error("analog pin still driven or pulled");

  fsel_zero_a: assert property ((port_a_function_select_low_q & ~MASK_FSEL_A_LOW) == 8'h00
    && (port_a_function_select_high_q & ~MASK_FSEL_A_HIGH) == 8'h00)
    else $error("unimplemented selector bit set");

  cmp_route_a: assert property ((tm0_cmp_sel && !wr_fs_al) |=> port_a_oe[PIN_A1]
    && port_a_out[PIN_A1] == $past(timer0_compare_output))
    else $error("timer0 compare not on pin");

  reset_pin_a: assert property ((b4_reset_sel && !wr_rsel) |=> external_reset_n_q == $past(port_b_in[PIN_B4])
    && !port_b_oe[PIN_B4])
    else $error("reset pin routing wrong");

  cap_gate_a: assert property (an5_sel |=> !timer0_capture_input_q)
    else $error("capture input not gated on analog pin");

  cmp_only_a: assert property (tm0_cmp_sel
    |=> port_a_out[0] == $past(port_a_data_latch_q[0]))
    else $error("compare output leaked onto another pin");

  latch_hold_b: assert property (!wr_b_data |=> $stable(port_b_data_latch_q))
    else $error("port B latch changed without write");

  rdata_hold_a: assert property (!mem_rd |=> $stable(mem_rdata_q))
    else $error("read data changed without read");

  pull_off_b: assert property (an3_sel |=> !port_b_pull[PIN_B3] && !port_b_oe[PIN_B3])
    else $error("analog port B pin still driven or pulled");

  wake_seen_c: cover property (low_power_mode ##1 wake_q);
  analog_sel_c: cover property (an0_sel ##1 analog_channel_en_q[0]);
  read_back_c: cover property (mem_rd && mem_addr == ADDR_PORT_B_DATA);
  reset_mode_c: cover property (b4_reset_sel ##1 !external_reset_n_q);

endmodule : gpm_port_top

// ### tb/gpm_pin_model.sv
// Behavioural pins and switches outside the two ports.
// Assumes the pad outputs come from the block and switch settings from the bench.
`timescale 1ns/1ns
module gpm_pin_model #(
  parameter int unsigned W = 8
) (
  // Clock
  input wire logic clock,
  // Block pad side
  input wire logic [W-1:0] pad_out,
  input wire logic [W-1:0] pad_oe,
  input wire logic [W-1:0] pad_pull,
  // Switch settings
  input wire logic [W-1:0] sw_en,
  input wire logic [W-1:0] sw_val,
  // Pin level seen by the block
  output logic [W-1:0] pin
);
  logic [W-1:0] float_q = '0;

  // Undriven pin without pull changes every cycle so no stale value can pass
  always @(posedge clock)
  begin
    float_q <= ~float_q;
  end

  // Block driver wins over a switch; pull only acts on an undriven pin
  assign pin = (pad_oe & pad_out) | (~pad_oe & sw_en & sw_val) | (~pad_oe & ~sw_en & pad_pull)
    | (~pad_oe & ~sw_en & ~pad_pull & float_q);
endmodule : gpm_pin_model

// ### tb/tb_top.sv
// Self-checking bench for the GPIO ports with pin-shared routing.
// Assumes the register map and timing of gpm_pkg and the design hand-over.
`timescale 1ns/1ns
module tb_top;
  import gpm_pkg::*;
  logic clock, rst_n, mem_wr, mem_rd, low_power_mode, t0c, t1c, wake_q, vref_en_q;
  logic t0clk, t0cap, t1clk, t1cap, ext_rst_n;
  logic [7:0] mem_addr, mem_wdata, mem_rdata_q, analog_channel_en_q;
  logic [7:0] pa_in, pa_out, pa_oe, pa_pull, a_en, a_val;
  logic [6:0] pb_in, pb_out, pb_oe, pb_pull, b_en, b_val;
  int fail_count, check_count, cycles, wakes;
  logic [7:0] tab [0:13][0:3] = '{'{8'h07, 8'h40, 8'h10, 8'h00}, '{8'h07, 8'h08, 8'h00, 8'h01},
    '{8'h07, 8'hc0, 8'h00, 8'h00}, '{8'h07, 8'h04, 8'h00, 8'h00}, '{8'h08, 8'h40, 8'h80, 8'h00},
    '{8'h08, 8'h10, 8'h40, 8'h00}, '{8'h08, 8'h04, 8'h20, 8'h00}, '{8'h08, 8'ha8, 8'h00, 8'h00},
    '{8'h08, 8'hfc, 8'h00, 8'h00}, '{8'h09, 8'h40, 8'h08, 8'h00}, '{8'h09, 8'h10, 8'h04, 8'h00},
    '{8'h09, 8'h04, 8'h02, 8'h00}, '{8'h09, 8'h02, 8'h01, 8'h00}, '{8'h09, 8'ha9, 8'h00, 8'h00}};

  gpm_port_top dut (.clock(clock), .rst_n(rst_n), .mem_addr(mem_addr), .mem_wr(mem_wr), .mem_rd(mem_rd),
    .mem_wdata(mem_wdata), .mem_rdata_q(mem_rdata_q), .low_power_mode(low_power_mode), .wake_q(wake_q),
    .port_a_in(pa_in), .port_a_out(pa_out), .port_a_oe(pa_oe), .port_a_pull(pa_pull), .port_b_in(pb_in),
    .port_b_out(pb_out), .port_b_oe(pb_oe), .port_b_pull(pb_pull), .timer0_compare_output(t0c),
    .timer1_compare_output(t1c), .timer0_clock_input_q(t0clk), .timer0_capture_input_q(t0cap),
    .timer1_clock_input_q(t1clk), .timer1_capture_input_q(t1cap), .external_reset_n_q(ext_rst_n),
    .analog_channel_en_q(analog_channel_en_q), .vref_en_q(vref_en_q));
  gpm_pin_model #(.W(8)) pins_a (.clock(clock), .pad_out(pa_out), .pad_oe(pa_oe), .pad_pull(pa_pull),
    .sw_en(a_en), .sw_val(a_val), .pin(pa_in));
  gpm_pin_model #(.W(7)) pins_b (.clock(clock), .pad_out(pb_out), .pad_oe(pb_oe), .pad_pull(pb_pull),
    .sw_en(b_en), .sw_val(b_val), .pin(pb_in));

  initial
  begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    check_count++;
    if (got !== exp)
    begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    mem_addr <= a;
    mem_wdata <= d;
    mem_wr <= 1'b1;
    @(posedge clock);
    mem_wr <= 1'b0;
  endtask : wr

  // Read data is sampled after the edge that follows the taken read
  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string name);
    @(posedge clock);
    mem_addr <= a;
    mem_rd <= 1'b1;
    @(posedge clock);
    mem_rd <= 1'b0;
    @(posedge clock);
    #1 chk(name, exp, mem_rdata_q);
  endtask : rd

  task automatic settle(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : settle

  task automatic done(input string name);
    $display("test %s done", name);
  endtask : done

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : print_verdict

  always @(posedge clock)
  begin
    cycles++;
    if (wake_q === 1'b1)
      wakes++;
    if (cycles == 3000)
    begin
      fail_count++;
      print_verdict();
    end
  end

  initial
  begin
    rst_n = 1'b0;
    {mem_wr, mem_rd, low_power_mode, t0c, t1c} = '0;
    {mem_addr, mem_wdata, a_en, a_val} = '0;
    {b_en, b_val} = '0;
    repeat (3) @(posedge clock);
    rst_n <= 1'b1;
    #1 chk("pa_oe reset", 8'h00, pa_oe);
    rd(ADDR_PORT_A_DIR, RST_PORT_A_DIR, "a dir");
    rd(ADDR_PORT_A_PU, 8'h00, "a pull");
    rd(ADDR_PORT_A_WAKE, 8'h00, "a wake");
    rd(ADDR_PORT_B_DIR, 8'h7f, "b dir");
    rd(ADDR_RESET_SEL, 8'h55, "reset sel");
    wr(8'h20, 8'hff);
    rd(8'h20, 8'h00, "unmapped");
    wr(ADDR_FSEL_A_LOW, 8'hff);
    wr(ADDR_FSEL_A_HIGH, 8'hff);
    wr(ADDR_FSEL_B, 8'hff);
    rd(ADDR_FSEL_A_LOW, 8'hcc, "sel a low");
    rd(ADDR_FSEL_A_HIGH, 8'hfc, "sel a high");
    rd(ADDR_FSEL_B, 8'hff, "sel b");
    for (int r = 7; r <= 9; r++)
      wr(r[7:0], 8'h00);
    done("registers");
    // Low nibble output, high nibble input driven by switches
    a_en <= 8'hf0;
    a_val <= 8'h30;
    wr(ADDR_PORT_A_DIR, 8'hf0);
    wr(ADDR_PORT_A_DATA, 8'h5a);
    wr(ADDR_PORT_A_PU, 8'hff);
    settle(2);
    chk("pa_oe", 8'h0f, pa_oe);
    chk("pa_pull", 8'hf0, pa_pull);
    chk("pa_out", 8'h0a, pa_out & 8'h0f);
    rd(ADDR_PORT_A_DATA, 8'h3a, "a data");
    @(posedge clock);
    a_val <= 8'hc0;
    rd(ADDR_PORT_A_DATA, 8'hca, "a data live");
    wr(ADDR_PORT_B_DIR, 8'h00);
    wr(ADDR_PORT_B_DATA, 8'hff);
    settle(2);
    chk("pb_oe", 8'h7f, {1'b0, pb_oe});
    rd(ADDR_PORT_B_DATA, 8'h5f, "b data");
    wr(ADDR_PORT_B_DIR, 8'h7f);
    done("ports");
    // Timer inputs need the pin set as input first
    wr(ADDR_PORT_A_DIR, 8'hff);
    wr(ADDR_PORT_B_PU, 8'h7f);
    a_en <= 8'hff;
    a_val <= 8'h28;
    b_en <= 7'h7f;
    b_val <= 7'h06;
    settle(3);
    chk("timer inputs", 8'h0f, {4'h0, t0clk, t0cap, t1clk, t1cap});
    chk("pb_pull", 8'h7f, {1'b0, pb_pull});
    wr(ADDR_FSEL_A_HIGH, 8'h40);
    a_en <= 8'h00;
    settle(2);
    chk("analog pull", 8'h7f, pa_pull);
    wr(ADDR_FSEL_A_HIGH, 8'h00);
    a_en <= 8'hff;
    wr(ADDR_FSEL_A_LOW, 8'h40);
    settle(3);
    chk("t0 clock analog", 8'h00, {7'h0, t0clk});
    for (int i = 0; i < 14; i++)
    begin
      wr(tab[i][0], 8'h00);
      wr(tab[i][0], tab[i][1]);
      settle(2);
      chk("analog en", tab[i][2], analog_channel_en_q);
      chk("vref en", tab[i][3], {7'h0, vref_en_q});
      wr(tab[i][0], 8'h00);
    end
    wr(ADDR_FSEL_A_LOW, 8'h04);
    wr(ADDR_FSEL_B, 8'h01);
    t0c <= 1'b1;
    settle(3);
    chk("a1 compare", 8'h02, pa_out & pa_oe & 8'h02);
    chk("a latch kept", 8'h5a, pa_out);
    chk("b0 compare", 8'h00, {1'b0, pb_out & pb_oe & 7'h01});
    @(posedge clock);
    t1c <= 1'b1;
    settle(3);
    chk("b0 compare", 8'h01, {1'b0, pb_out & pb_oe & 7'h01});
    wr(ADDR_FSEL_A_LOW, 8'h00);
    wr(ADDR_FSEL_B, 8'h00);
    done("routing");
    b_val <= 7'h00;
    wr(ADDR_RESET_SEL, RSEL_RESET);
    settle(3);
    chk("ext reset low", 8'h00, {7'h0, ext_rst_n});
    wr(ADDR_RESET_SEL, RSEL_GPIO);
    settle(3);
    chk("ext reset gpio", 8'h01, {7'h0, ext_rst_n});
    done("reset pin");
    wr(ADDR_PORT_A_WAKE, 8'h01);
    a_val <= 8'hff;
    low_power_mode <= 1'b1;
    settle(2);
    wakes = 0;
    @(posedge clock);
    a_val <= 8'hfe;
    settle(4);
    chk("wake pin0", 8'h01, wakes[7:0]);
    @(posedge clock);
    a_val <= 8'hff;
    settle(2);
    @(posedge clock);
    a_val <= 8'hfd;
    settle(4);
    chk("wake pin1 off", 8'h01, wakes[7:0]);
    @(posedge clock);
    a_val <= 8'hff;
    low_power_mode <= 1'b0;
    settle(2);
    @(posedge clock);
    a_val <= 8'hfe;
    settle(4);
    chk("wake awake", 8'h01, wakes[7:0]);
    done("wake");
    print_verdict();
  end
endmodule : tb_top
